// ===== rtl/mlp_consts.svh
// Functional notes
// - Remap register keeps value on pin reset
// - Priority register ch1/ch2 at 27h
// - Priority register ch3/ch4 at 28h
// - Three-bit fields, all bits RW, reset zero
// - Priorities used only when select bit high
// - Shut off channels with priority >= code
// - Lower priority value than code unaffected
// - Higher value means lower priority
// - Value 101 off for all codes but 110 and 111
// - Equal priorities shut down together
// - Shutdown clears bits like channel reset
// - Shutdown keeps fault cool-down timers running
// - Each code acts at once, no memory
// - Policing to FF, measurements cleared
`ifndef MLP_CONSTS_SVH
`define MLP_CONSTS_SVH
`define MLP_CMD_PRIO12     8'h27
`define MLP_CMD_PRIO34     8'h28
`define MLP_PRIO_RST       8'h00
`define MLP_REMAP_RST      8'hE4
`define MLP_POLICE_RST     8'hFF
`define MLP_FIELD_LO       0
`define MLP_FIELD_HI       4
`endif

// ===== rtl/mlp_pkg.sv
`default_nettype none
package mlp_pkg;
   typedef logic [2:0] mlp_prio_t;
   typedef logic [7:0] mlp_byte_t;
endpackage
`default_nettype wire

// ===== rtl/mlp_priority_shutdown.sv
`include "mlp_consts.svh"
`default_nettype none
module mlp_priority_shutdown
   import mlp_pkg::*;
#(
   parameter int NCH = 4
)
(
   input  wire logic           ref_clk,
   input  wire logic           srst,
   input  wire logic           pin_reset_n,
   input  wire logic           reg_wr,
   input  wire logic           reg_rd,
   input  wire logic [7:0]     reg_cmd,
   input  wire logic [7:0]     reg_wdata,
   output var  logic [7:0]     reg_rdata,
   output var  logic           reg_rvalid,
   input  wire logic           multibit_priority_select,
   input  wire logic           fast_shutdown_code_valid,
   input  wire logic [2:0]     fast_shutdown_code_input,
   input  wire logic           remap_wr,
   input  wire logic [7:0]     remap_wdata,
   output var  logic [7:0]     remap_q,
   output var  logic [NCH-1:0] channel_off_pulse,
   output var  logic [NCH-1:0] channel_clear_pulse,
   output var  logic [NCH-1:0] police_reload_pulse,
   output var  logic [NCH-1:0] meas_clear_pulse,
   output var  logic [NCH-1:0] cooldown_keep
);

   // ****************************************
   // Local constants
   // ****************************************
   // Two bytes give fields to four channels; any further channel is never cut
   localparam int PRIO_CH = 4;
   // Width of one channel's field
   localparam int FIELD_W = 3;

   // ****************************************
   // Functions
   // ****************************************
   function automatic mlp_prio_t field_of(input logic [7:0] r, input int lo);
      field_of = r[lo +: FIELD_W];
   endfunction

   // Rank falls as the value rises, so a code cuts every field at or above it
   function automatic logic cut_by(input mlp_prio_t level, input mlp_prio_t code);
      cut_by = (level >= code);
   endfunction

   function automatic logic cmd_is(input logic [7:0] cmd, input logic [7:0] target);
      cmd_is = (cmd == target);
   endfunction

   // ****************************************
   // Register decode
   // ****************************************
   logic [7:0] prio12_q;
   logic [7:0] prio12_d;
   logic [7:0] prio34_q;
   logic [7:0] prio34_d;
   logic [7:0] rdata_d;
   wire        hit12;
   wire        hit34;
   wire        wr12;
   wire        wr34;
   wire  [7:0] rd_mux;

   assign hit12 = cmd_is(reg_cmd, `MLP_CMD_PRIO12);
   assign hit34 = cmd_is(reg_cmd, `MLP_CMD_PRIO34);
   assign wr12  = reg_wr & hit12;
   assign wr34  = reg_wr & hit34;

   // Unmapped commands read back zero; writes to them fall away
   assign rd_mux = hit12 ? prio12_q : (hit34 ? prio34_q : 8'h00);

   // Whole byte is kept, spare bits 7 and 3 included
   assign prio12_d = wr12 ? reg_wdata : prio12_q;
   assign prio34_d = wr34 ? reg_wdata : prio34_q;

   // Read data holds until the next read
   assign rdata_d = reg_rd ? rd_mux : reg_rdata;

   // ****************************************
   // Priority fields
   // ****************************************
   wire mlp_prio_t prio [PRIO_CH];

   assign prio[0] = field_of(prio12_q, `MLP_FIELD_LO);
   assign prio[1] = field_of(prio12_q, `MLP_FIELD_HI);
   assign prio[2] = field_of(prio34_q, `MLP_FIELD_LO);
   assign prio[3] = field_of(prio34_q, `MLP_FIELD_HI);

   // ****************************************
   // Shutdown selection
   // ****************************************
   // No code is stored: each one meets the live fields in its own cycle
   wire           act;
   wire [NCH-1:0] hit;

   assign act = fast_shutdown_code_valid & multibit_priority_select;

   for (genvar g = 0; g < NCH; g++)
   begin : g_ch
      if (g < PRIO_CH)
      begin : g_live
         // Equal fields are cut together by the same code
         assign hit[g] = act & cut_by(prio[g], fast_shutdown_code_input);
      end
      else
      begin : g_spare
         assign hit[g] = 1'b0;
      end
   end

   // ****************************************
   // Priority registers
   // ****************************************
   // Writes land at the edge that takes the strobe
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         prio12_q <= `MLP_PRIO_RST;
      else
         prio12_q <= prio12_d;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         prio34_q <= `MLP_PRIO_RST;
      else
         prio34_q <= prio34_d;
   end

   // ****************************************
   // Read port
   // ****************************************
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= rdata_d;
   end

   // Strobe rises one cycle after the read
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         reg_rvalid <= 1'b0;
      else
         reg_rvalid <= reg_rd;
   end

   // ****************************************
   // Remap register
   // ****************************************
   // Start value comes from srst only; a low pin reset freezes it, never clears it
   wire       remap_take;
   wire [7:0] remap_d;

   assign remap_take = remap_wr & pin_reset_n;
   assign remap_d    = remap_take ? remap_wdata : remap_q;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         remap_q <= `MLP_REMAP_RST;
      else
         remap_q <= remap_d;
   end

   // ****************************************
   // Per-channel turn-off strobes
   // ****************************************
   // All strobes copy one selection, so every side effect lines up
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         channel_off_pulse <= '0;
      else
         channel_off_pulse <= hit;
   end

   // Clear strobe mirrors a per-channel reset
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         channel_clear_pulse <= '0;
      else
         channel_clear_pulse <= hit;
   end

   // Policing limit returns to FF in the channel logic
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         police_reload_pulse <= '0;
      else
         police_reload_pulse <= hit;
   end

   // Measurement results are cleared in the channel logic
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         meas_clear_pulse <= '0;
      else
         meas_clear_pulse <= hit;
   end

   // Cool-down timers keep counting, unlike a channel reset
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         cooldown_keep <= '0;
      else
         cooldown_keep <= hit;
   end

endmodule
`default_nettype wire

// ===== testbench/mlp_props.sv
`default_nettype none
module mlp_props
#(
   parameter int NCH = 4
)
(
   input wire logic           ref_clk,
   input wire logic           srst,
   input wire logic           multibit_priority_select,
   input wire logic           fast_shutdown_code_valid,
   input wire logic [2:0]     fast_shutdown_code_input,
   input wire logic [NCH-1:0] channel_off_pulse,
   input wire logic [NCH-1:0] channel_clear_pulse,
   input wire logic [NCH-1:0] police_reload_pulse,
   input wire logic [NCH-1:0] meas_clear_pulse,
   input wire logic [NCH-1:0] cooldown_keep
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic tk = fast_shutdown_code_valid & multibit_priority_select;
   wire logic [NCH-1:0] off = channel_off_pulse;
   wire logic nsel = !multibit_priority_select;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   idle_off_a: assert property (!tk |=> off == '0) else $error("stray off");
   sel_low_a: assert property (nsel |=> off == '0) else $error("off unselected");
   code_zero_a: assert property (tk && !fast_shutdown_code_input |=> &off) else $error("c0");
   off_cause_a: assert property (|off |-> $past(tk)) else $error("late off");
   clr_tie_a: assert property (channel_clear_pulse == off) else $error("clear");
   pol_tie_a: assert property (police_reload_pulse == off) else $error("police");
   meas_tie_a: assert property (meas_clear_pulse == off) else $error("meas");
   keep_tie_a: assert property (cooldown_keep == off) else $error("keep");
endmodule
bind mlp_priority_shutdown mlp_props #(.NCH(NCH)) u_props (.*);
`default_nettype wire

// ===== testbench/mlp_host.sv
`default_nettype none
module mlp_host
(
   input  wire logic       ref_clk,
   output var  logic       sel,
   output var  logic       vld,
   output var  logic [2:0] code
);
   timeunit 1ns; timeprecision 1ps;
   initial {sel, vld, code} = '0;
   task automatic send(input logic s, input logic [2:0] c); // One cycle of valid with code c, then valid drops and code inverts
      @(negedge ref_clk) {sel, vld, code} = {s, 1'b1, c};
      @(negedge ref_clk) {vld, code} = {1'b0, ~c};
   endtask
endmodule
`default_nettype wire

// ===== testbench/mlp_priority_shutdown_bench.sv
`include "mlp_consts.svh"
`default_nettype none
module mlp_priority_shutdown_bench;
   timeunit 1ns; timeprecision 1ps;
   logic ref_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, pin_reset_n = 1, remap_wr = 0, s;
   logic [7:0] reg_cmd = 0, reg_wdata = 0, remap_wdata = 8'h1B, reg_rdata, remap_q, p, q;
   logic [3:0] channel_off_pulse; logic [2:0] code, c; logic sel, vld;
   logic reg_rvalid;
   int failures = 0, n_tests = 0, seed = 23578;
   always #2.5 ref_clk = ~ref_clk;
   mlp_host u_mlp_host (.*);
   mlp_priority_shutdown u_mlp_priority_shutdown (.*, .channel_clear_pulse(),
      .police_reload_pulse(), .meas_clear_pulse(), .cooldown_keep(),
      .multibit_priority_select(sel), .fast_shutdown_code_valid(vld),
      .fast_shutdown_code_input(code));
   task automatic chk(input logic [7:0] g, e);
      n_tests++;
      if (g !== e) begin failures++; $display("[ERR] %0t %h %h", $time, g, e); end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, d);
      @(negedge ref_clk) {reg_wr, reg_rd, reg_cmd, reg_wdata} = {w, !w, a, d};
      @(negedge ref_clk) {reg_wr, reg_rd, reg_wdata} = {2'b0, ~d};
      chk({7'h0, reg_rvalid}, {7'h0, !w});
   endtask
   function automatic logic [7:0] exp_off();
      return {4'h0, {4{s}} & {q[6:4] >= c, q[2:0] >= c, p[6:4] >= c, p[2:0] >= c}};
   endfunction
   task automatic finish_test;
      $display("failures %0d n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("[ PASS ]"); else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin repeat (4000) @(posedge ref_clk); failures++; finish_test; end
   initial
   begin
      repeat (12) @(negedge ref_clk);
      srst = 0;
      chk(remap_q, `MLP_REMAP_RST);
      bus(0, 8'h27, 8'h00);
      chk(reg_rdata, 8'h00);
      bus(0, 8'h28, 8'h00);
      chk(reg_rdata, 8'h00);
      for (int i = 0; i < 40; i++)
      begin
         // Equal fives first: every code, all channels at once
         {p, q, s, c} = i < 8 ? {16'h55D5, 1'b1, 3'(i)} : 20'($random(seed));
         bus(1, 8'h27, p); bus(1, 8'h28, q);
         u_mlp_host.send(s, c); chk({4'h0, channel_off_pulse}, exp_off());
         bus(0, 8'h27, 0); chk(reg_rdata, p);
         bus(0, 8'h28, 0); chk(reg_rdata, q);
      end
      // Unmapped command: write falls away, read gives zero
      bus(1, 8'h29, 8'hFF);
      bus(0, 8'h29, 8'h00);
      chk(reg_rdata, 8'h00);
      bus(0, 8'h27, 8'h00);
      chk(reg_rdata, p);
      remap_wr = 1;
      @(negedge ref_clk) pin_reset_n = 0;
      remap_wdata = 8'h39;
      @(negedge ref_clk) chk(remap_q, 8'h1B);
      {remap_wr, pin_reset_n} = 2'b01;
      srst = 1;
      @(negedge ref_clk) srst = 0;
      chk(remap_q, `MLP_REMAP_RST);
      bus(0, 8'h27, 8'h00);
      chk(reg_rdata, 8'h00);
      bus(0, 8'h28, 8'h00);
      chk(reg_rdata, 8'h00);
      finish_test;
   end
endmodule
`default_nettype wire
